// ### hw/asf_defs.svh
// Function
// - Results are sign-extended two's complement values
// - Axis results readable at result bytes 0x02-0x07
// - Queue enabled limits widths to 6-12 bits
// - Width field decodes 6,7,8,10,12,14 bits
// - Range field decodes 2,4,8,16,12 g
// - Queue disabled gates queue interrupts, levels, modes
// - Queue flags show defaults while disabled
// - Normal mode writes while entries remain free
// - Watermark mode drops samples at threshold
// - Disabled writes outputs, enabled writes queue
// - Queue reset clears pointers and contents
// - Drive mode selects open-drain or push-pull
// - Polarity selects active-low or active-high request
// - Wake motion raises interrupt when enabled
// - New sample raises interrupt when enabled
// - Empty queue raises interrupt when enabled
// - Full queue raises interrupt when enabled
// - Threshold level reached raises interrupt
// - Watch motion interrupt only in watch state
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH
// ==========================================
// Register indices, byte address is index * 4
`define ASF_IDX_XL       8'h02
`define ASF_IDX_ZH       8'h07
`define ASF_IDX_STATUS   8'h08
`define ASF_IDX_FORMAT   8'h15
`define ASF_IDX_QUEUE    8'h16
`define ASF_IDX_IRQ      8'h17
`define ASF_REG_RESET    8'h00
// ==========================================
// Field positions
`define ASF_F_QRST       7
`define ASF_F_QEN        6
`define ASF_F_QMODE      5
`define ASF_F_DRIVE      0
`define ASF_F_POL        1
`define ASF_F_WAKE       2
`define ASF_F_ACQ        3
`define ASF_F_EMPTY      4
`define ASF_F_FULL       5
`define ASF_F_THR        6
`define ASF_F_WATCH      7
// ==========================================
// Queue geometry
`define ASF_Q_DEPTH      6'd32
`endif

// ### hw/asf_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module asf_fmt (
   input  wire logic [13:0] i_raw,
   input  wire logic [2:0]  i_width_sel,
   input  wire logic        i_queue_en,
   output logic      [15:0] o_res
);
   import asf_pkg::*;
   logic signed [15:0] ext;
   assign ext = {{2{i_raw[13]}}, i_raw};
   // ==========================================
   // Width decode and arithmetic shift
   always_comb begin
      case (i_width_sel)
         ASF_W6:  o_res = 16'(ext >>> 8);
         ASF_W7:  o_res = 16'(ext >>> 7);
         ASF_W8:  o_res = 16'(ext >>> 6);
         ASF_W10: o_res = 16'(ext >>> 4);
         ASF_W12: o_res = 16'(ext >>> 2);
         default: o_res = i_queue_en ? 16'(ext >>> 2) : ext;
      endcase
   end
endmodule : asf_fmt
`default_nettype wire

// ### hw/asf_pkg.sv
// ==========================================
// Shared types
package asf_pkg;
   typedef logic [15:0] asf_result_t;
   typedef logic [13:0] asf_raw_t;
   typedef logic [35:0] asf_entry_t;
   typedef logic [5:0]  asf_count_t;
   typedef enum logic [2:0] {
      ASF_W6  = 3'h0,
      ASF_W7  = 3'h1,
      ASF_W8  = 3'h2,
      ASF_W10 = 3'h3,
      ASF_W12 = 3'h4,
      ASF_W14 = 3'h5
   } asf_width_t;
endpackage : asf_pkg

// ### hw/asf_queue.sv
`timescale 1ns/100ps
`default_nettype none
module asf_queue (
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_clr,
   input  wire logic             i_wr,
   input  wire logic [35:0]      i_wdata,
   input  wire logic             i_rd,
   output logic      [35:0]      o_rdata,
   output logic      [5:0]       o_count
);
   import asf_pkg::*;
   logic [4:0]  wptr;
   logic [4:0]  rptr;
   asf_entry_t  mem [32];
   logic        do_wr;
   logic        do_rd;
   assign do_wr   = i_wr && (o_count != 6'd32);
   assign do_rd   = i_rd && (o_count != 6'd0);
   assign o_rdata = mem[rptr];
   // ==========================================
   // Pointers and count
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_clr) begin
         wptr    <= 5'h00;
         rptr    <= 5'h00;
         o_count <= 6'h00;
      end else begin
         if (do_wr) wptr <= wptr + 5'h01;
         if (do_rd) rptr <= rptr + 5'h01;
         o_count <= o_count + 6'(do_wr) - 6'(do_rd);
      end
   end
   // ==========================================
   // Entries
   for (genvar e = 0; e < 32; e++) begin : g_ent
      always_ff @(posedge i_clk) begin
         if (!i_nrst || i_clr) mem[e] <= 36'h0;
         else if (do_wr && wptr == 5'(e)) mem[e] <= i_wdata;
      end
   end
endmodule : asf_queue
`default_nettype wire

// ### hw/asf_top.sv
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "asf_defs.svh"
module asf_top (
   input  wire logic               I_SYS_CLK,
   input  wire logic               I_NRST,
   input  wire logic               I_HSEL,
   input  wire logic [31:0]        I_HADDR,
   input  wire logic [1:0]         I_HTRANS,
   input  wire logic               I_HWRITE,
   input  wire logic [2:0]         I_HSIZE,
   input  wire logic [31:0]        I_HWDATA,
   input  wire logic               I_HREADY,
   output logic      [31:0]        O_HRDATA,
   output logic                    O_HREADYOUT,
   output logic                    O_HRESP,
   input  wire logic               I_SAMPLE_VALID,
   input  wire asf_pkg::asf_raw_t  I_SAMPLE_X,
   input  wire asf_pkg::asf_raw_t  I_SAMPLE_Y,
   input  wire asf_pkg::asf_raw_t  I_SAMPLE_Z,
   input  wire logic               I_WAKE_MOTION,
   input  wire logic               I_WATCH_MOTION,
   input  wire logic               I_WATCH_AND_ACTIVE_STATE,
   output logic      [2:0]         O_FULL_SCALE,
   output logic                    O_IRQ_PIN_OUT,
   output logic                    O_IRQ_PIN_OE
);
   import asf_pkg::*;
   // ==========================================
   // Declarations
   logic [7:0]  sample_format_control;
   logic [7:0]  sample_queue_control;
   logic [7:0]  interrupt_enable_control;
   asf_result_t res_x;
   asf_result_t res_y;
   asf_result_t res_z;
   asf_result_t fmt_x;
   asf_result_t fmt_y;
   asf_result_t fmt_z;
   asf_entry_t  q_head;
   asf_count_t  q_count;
   logic        q_wr;
   logic        q_rd;
   logic        queue_en;
   logic        queue_mode;
   logic        queue_rst;
   logic [4:0]  queue_threshold_level;
   logic        new_sample;
   logic        wake_flag;
   logic        watch_flag;
   logic        st_empty;
   logic        st_full;
   logic        st_level;
   logic [7:0]  status;
   logic        irq_any;
   logic        pin_level;
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  acc_idx;
   logic        addr_ok;
   logic        addr_take;
   logic        sample_take;
   logic [31:0] next_rdata;
   logic        rd_status;
   logic        rd_pop;
   logic        irq_on_new_sample;
   logic        irq_on_queue_level;
   logic        irq_on_watch_motion;
   logic        irq_output_drive_mode;
   logic        irq_polarity;
   assign queue_rst             = sample_queue_control[`ASF_F_QRST];
   assign queue_en              = sample_queue_control[`ASF_F_QEN];
   assign queue_mode            = sample_queue_control[`ASF_F_QMODE];
   assign queue_threshold_level = sample_queue_control[4:0];
   assign irq_output_drive_mode = interrupt_enable_control[`ASF_F_DRIVE];
   assign irq_polarity          = interrupt_enable_control[`ASF_F_POL];
   assign irq_on_new_sample     = interrupt_enable_control[`ASF_F_ACQ];
   assign irq_on_queue_level    = interrupt_enable_control[`ASF_F_THR];
   assign irq_on_watch_motion   = interrupt_enable_control[`ASF_F_WATCH];
   // ==========================================
   // Sample formatting
   asf_fmt u_fmt_x (
      .i_raw       (I_SAMPLE_X),
      .i_width_sel (sample_format_control[2:0]),
      .i_queue_en  (queue_en),
      .o_res       (fmt_x)
   );
   asf_fmt u_fmt_y (
      .i_raw       (I_SAMPLE_Y),
      .i_width_sel (sample_format_control[2:0]),
      .i_queue_en  (queue_en),
      .o_res       (fmt_y)
   );
   asf_fmt u_fmt_z (
      .i_raw       (I_SAMPLE_Z),
      .i_width_sel (sample_format_control[2:0]),
      .i_queue_en  (queue_en),
      .o_res       (fmt_z)
   );
   // ==========================================
   // Sample queue
   always_comb begin
      q_wr = 1'b0;
      if (I_SAMPLE_VALID && queue_en) begin
         if (queue_mode)
            q_wr = (q_count < 6'(queue_threshold_level));
         else
            q_wr = (q_count != `ASF_Q_DEPTH);
      end
   end
   assign sample_take = queue_en ? q_wr : I_SAMPLE_VALID;
   asf_queue u_queue (
      .i_clk   (I_SYS_CLK),
      .i_nrst  (I_NRST),
      .i_clr   (queue_rst),
      .i_wr    (q_wr),
      .i_wdata ({fmt_z[11:0], fmt_y[11:0], fmt_x[11:0]}),
      .i_rd    (q_rd),
      .o_rdata (q_head),
      .o_count (q_count)
   );
   // ==========================================
   // Direct result registers
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         res_x <= 16'h0000;
         res_y <= 16'h0000;
         res_z <= 16'h0000;
      end else if (I_SAMPLE_VALID && !queue_en) begin
         res_x <= fmt_x;
         res_y <= fmt_y;
         res_z <= fmt_z;
      end
   end
   // ==========================================
   // Status flags, set wins over read clear
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         new_sample <= 1'b0;
         wake_flag  <= 1'b0;
         watch_flag <= 1'b0;
      end else begin
         new_sample <= sample_take || (new_sample && !rd_status);
         wake_flag  <= I_WAKE_MOTION || (wake_flag && !rd_status);
         watch_flag <= (I_WATCH_MOTION && I_WATCH_AND_ACTIVE_STATE)
                       || (watch_flag && !rd_status);
      end
   end
   assign st_empty = !queue_en || (q_count == 6'd0);
   assign st_full  = queue_en && (q_count == `ASF_Q_DEPTH);
   assign st_level = queue_en && (q_count >= 6'(queue_threshold_level));
   assign status   = {2'b00, watch_flag, wake_flag, st_level, st_full, st_empty, new_sample};
   // ==========================================
   // Interrupt combine and pin
   assign irq_any =
      (irq_on_new_sample && new_sample)
      || (interrupt_enable_control[`ASF_F_WAKE] && wake_flag)
      || (irq_on_watch_motion && watch_flag)
      || (queue_en && interrupt_enable_control[`ASF_F_EMPTY] && q_count == 6'd0)
      || (interrupt_enable_control[`ASF_F_FULL] && st_full)
      || (irq_on_queue_level && st_level);
   assign pin_level = irq_polarity ? irq_any : !irq_any;
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         O_IRQ_PIN_OUT <= 1'b0;
         O_IRQ_PIN_OE  <= 1'b0;
      end else if (irq_output_drive_mode) begin
         O_IRQ_PIN_OUT <= pin_level;
         O_IRQ_PIN_OE  <= 1'b1;
      end else begin
         O_IRQ_PIN_OUT <= 1'b0;
         O_IRQ_PIN_OE  <= !pin_level;
      end
   end
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) O_FULL_SCALE <= 3'h0;
      else if (sample_format_control[6:4] <= 3'h4) O_FULL_SCALE <= sample_format_control[6:4];
      else O_FULL_SCALE <= 3'h0;
   end
   // ==========================================
   // Bus slave, reads take one wait state
   assign addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;
   assign addr_ok   = (I_HADDR[31:10] == 22'h0) && (I_HADDR[1:0] == 2'b00);
   assign rd_status = rd_pend && (acc_idx == `ASF_IDX_STATUS);
   assign rd_pop    = rd_pend && (acc_idx == `ASF_IDX_ZH);
   assign q_rd      = rd_pop && queue_en;
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         wr_pend     <= 1'b0;
         rd_pend     <= 1'b0;
         acc_idx     <= 8'hff;
         O_HREADYOUT <= 1'b1;
         O_HRESP     <= 1'b0;
      end else begin
         wr_pend     <= addr_take && I_HWRITE;
         rd_pend     <= addr_take && !I_HWRITE;
         O_HREADYOUT <= !(addr_take && !I_HWRITE);
         if (addr_take) acc_idx <= addr_ok ? I_HADDR[9:2] : 8'hff;
      end
   end
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) begin
         sample_format_control    <= `ASF_REG_RESET;
         sample_queue_control     <= `ASF_REG_RESET;
         interrupt_enable_control <= `ASF_REG_RESET;
      end else if (wr_pend) begin
         if (acc_idx == `ASF_IDX_FORMAT) sample_format_control <= I_HWDATA[7:0];
         else if (acc_idx == `ASF_IDX_QUEUE) sample_queue_control <= I_HWDATA[7:0];
         else if (acc_idx == `ASF_IDX_IRQ) interrupt_enable_control <= I_HWDATA[7:0];
      end
   end
   // ==========================================
   // Read mux, queue head when enabled
   always_comb begin
      asf_result_t hx;
      asf_result_t hy;
      asf_result_t hz;
      hx = queue_en ? {{4{q_head[11]}}, q_head[11:0]} : res_x;
      hy = queue_en ? {{4{q_head[23]}}, q_head[23:12]} : res_y;
      hz = queue_en ? {{4{q_head[35]}}, q_head[35:24]} : res_z;
      next_rdata = 32'h0;
      if (acc_idx == `ASF_IDX_XL) next_rdata = {24'h0, hx[7:0]};
      else if (acc_idx == 8'h03) next_rdata = {24'h0, hx[15:8]};
      else if (acc_idx == 8'h04) next_rdata = {24'h0, hy[7:0]};
      else if (acc_idx == 8'h05) next_rdata = {24'h0, hy[15:8]};
      else if (acc_idx == 8'h06) next_rdata = {24'h0, hz[7:0]};
      else if (acc_idx == `ASF_IDX_ZH) next_rdata = {24'h0, hz[15:8]};
      else if (acc_idx == `ASF_IDX_STATUS) next_rdata = {24'h0, status};
      else if (acc_idx == `ASF_IDX_FORMAT) next_rdata = {24'h0, sample_format_control};
      else if (acc_idx == `ASF_IDX_QUEUE) next_rdata = {24'h0, sample_queue_control};
      else if (acc_idx == `ASF_IDX_IRQ) next_rdata = {24'h0, interrupt_enable_control};
   end
   always_ff @(posedge I_SYS_CLK) begin
      if (!I_NRST) O_HRDATA <= 32'h0;
      else if (rd_pend) O_HRDATA <= next_rdata;
   end
   // ==========================================
   // Assertions
   AST_QUEUE_OFF_NO_WRITE: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      !queue_en |-> !q_wr) else $error("queue written while disabled");
   AST_WATERMARK_DROP: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (queue_en && queue_mode && !queue_rst && q_count >= 6'(queue_threshold_level))
      |=> q_count <= $past(q_count)) else $error("watermark queue grew");
   AST_NORMAL_FILL: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (queue_en && !queue_mode && !queue_rst && I_SAMPLE_VALID && !q_rd
       && q_count < `ASF_Q_DEPTH) |=> q_count == $past(q_count) + 6'd1)
      else $error("normal mode sample not stored");
   AST_QUEUE_RESET: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      queue_rst |=> (q_count == 6'd0 && q_head == 36'h0)) else $error("queue reset failed");
   AST_FLAG_DEFAULTS: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      !queue_en |-> status[3:1] == 3'b001) else $error("queue flags not default");
   AST_DIRECT_RESULT: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (I_SAMPLE_VALID && !queue_en) |=> res_z == $past(fmt_z)) else $error("direct write missing");
   AST_PUSH_PULL: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      irq_output_drive_mode |=> O_IRQ_PIN_OE) else $error("push-pull not driven");
   AST_OPEN_DRAIN_LOW: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (!irq_output_drive_mode && !irq_polarity && irq_any) |=> (O_IRQ_PIN_OE && !O_IRQ_PIN_OUT))
      else $error("active-low request not pulled low");
   AST_FULL_IRQ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (interrupt_enable_control[`ASF_F_FULL] && st_full) |-> irq_any) else $error("full irq missing");
   AST_SIGN_EXT: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      I_SAMPLE_VALID |-> fmt_x[15] == I_SAMPLE_X[13]) else $error("result not sign extended");
   AST_WAKE_IRQ: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (I_WAKE_MOTION && interrupt_enable_control[`ASF_F_WAKE] && !wr_pend) |=> ##1 O_IRQ_PIN_OE
      || irq_output_drive_mode || irq_polarity) else $error("wake irq missing");
   COV_QUEUE_FULL: cover property (@(posedge I_SYS_CLK) disable iff (!I_NRST) st_full);
   COV_WATERMARK: cover property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      queue_mode && st_level && I_SAMPLE_VALID);
   COV_POP: cover property (@(posedge I_SYS_CLK) disable iff (!I_NRST) q_rd && q_count != 6'd0);
endmodule : asf_top
`default_nettype wire

// ### tb/asf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module asf_host_model (
   input  wire logic i_irq_out,
   input  wire logic i_irq_oe,
   output logic      o_irq_level
);
   // ==========================================
   // Interrupt line as the host sees it, with external pull-up
   assign o_irq_level = i_irq_oe ? i_irq_out : 1'b1;
endmodule : asf_host_model
`default_nettype wire

// ### tb/asf_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module asf_top_tb;
   import asf_pkg::*;
   // ==========================================
   // Signals
   logic        clk, nrst, hsel, hwrite, hready, hresp;
   logic        smp_valid, wake, watch, watch_st, irq_out, irq_oe, irq_level;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, full_scale;
   asf_raw_t    sx, sy, sz;
   int          miscompares, comparisons, cycles;

   asf_top i_dut (
      .I_SYS_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_SAMPLE_VALID(smp_valid), .I_SAMPLE_X(sx), .I_SAMPLE_Y(sy), .I_SAMPLE_Z(sz),
      .I_WAKE_MOTION(wake), .I_WATCH_MOTION(watch), .I_WATCH_AND_ACTIVE_STATE(watch_st),
      .O_FULL_SCALE(full_scale), .O_IRQ_PIN_OUT(irq_out), .O_IRQ_PIN_OE(irq_oe)
   );
   asf_host_model i_host (.i_irq_out(irq_out), .i_irq_oe(irq_oe), .o_irq_level(irq_level));

   // ==========================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic report_and_stop();
      if (miscompares == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {22'h0, idx, 2'b00};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      ahb(1'b1, idx, d);
   endtask : wr

   task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      ahb(1'b0, idx, 8'h00);
      check(name, rd, exp);
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : rdchk

   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         smp_valid <= 1'b1;
      end
      @(posedge clk);
      smp_valid <= 1'b0;
   endtask : push

   task automatic pop(input int n);
      for (int i = 0; i < n; i++) ahb(1'b0, 8'h07, 8'h00);
   endtask : pop

   task automatic pin(input logic oe, input logic lvl);
      repeat (4) @(posedge clk);
      check("irq_oe", {31'h0, irq_oe}, {31'h0, oe});
      check("irq_level", {31'h0, irq_level}, {31'h0, lvl});
   endtask : pin

   // ==========================================
   // Scenarios
   task automatic t_regs();
      rdchk("format_rst", 8'h15, 32'h0);
      rdchk("queue_rst", 8'h16, 32'h0);
      rdchk("irq_rst", 8'h17, 32'h0);
      rdchk("unmapped", 8'h30, 32'h0);
      for (int c = 0; c < 6; c++) begin
         wr(8'h15, 8'(c * 16 + 5));
         repeat (2) @(posedge clk);
         check("full_scale", {29'h0, full_scale}, (c < 5) ? c : 0);
      end
      rdchk("format_rd", 8'h15, 32'h55);
   endtask : t_regs

   task automatic t_direct();
      wr(8'h15, 8'h05);
      push(1);
      rdchk("xl", 8'h02, 32'h45);
      rdchk("xh", 8'h03, 32'he3);
      rdchk("yh", 8'h05, 32'h01);
      rdchk("zh", 8'h07, 32'hff);
      rdchk("status_new", 8'h08, 32'h03);
      rdchk("status_clr", 8'h08, 32'h02);
   endtask : t_direct

   task automatic t_full();
      wr(8'h17, 8'h23);
      wr(8'h16, 8'h44); // threshold kept within 1..31
      push(33);
      pin(1'b1, 1'b1);
      rdchk("status_full", 8'h08, 32'h0d);
      pop(32);
      rdchk("status_drain", 8'h08, 32'h02);
      pin(1'b1, 1'b0);
   endtask : t_full

   task automatic t_mark();
      wr(8'h16, 8'h64);
      push(10);
      rdchk("status_mark", 8'h08, 32'h09);
      pop(4);
      rdchk("status_mark_drain", 8'h08, 32'h02);
      wr(8'h16, 8'h44);
      push(3);
      wr(8'h16, 8'hc4);
      wr(8'h16, 8'h44);
      rdchk("status_qrst", 8'h08, 32'h03);
   endtask : t_mark

   task automatic t_irq();
      wr(8'h17, 8'h50);
      wr(8'h16, 8'h00);
      pin(1'b0, 1'b1);
      wr(8'h16, 8'h41);
      pin(1'b1, 1'b0);
      wr(8'h16, 8'h00);
      wr(8'h17, 8'h08);
      push(1);
      pin(1'b1, 1'b0);
      rdchk("status_acq", 8'h08, 32'h03);
      pin(1'b0, 1'b1);
      wr(8'h17, 8'h80);
      @(posedge clk) watch <= 1'b1;
      @(posedge clk) watch <= 1'b0;
      pin(1'b0, 1'b1);
      ahb(1'b0, 8'h08, 8'h00);
      watch_st <= 1'b1;
      @(posedge clk) watch <= 1'b1;
      @(posedge clk) watch <= 1'b0;
      pin(1'b1, 1'b0);
      ahb(1'b0, 8'h08, 8'h00);
      wr(8'h17, 8'h04);
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      pin(1'b1, 1'b0);
      ahb(1'b0, 8'h08, 8'h00);
      pin(1'b0, 1'b1);
   endtask : t_irq

   // ==========================================
   // Main sequence
   initial begin
      {nrst, hsel, hwrite, smp_valid, wake, watch, watch_st} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      sx = 14'h2345;
      sy = 14'h0123;
      sz = 14'h3ffe;
      {miscompares, comparisons, cycles} = '0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_direct();
      t_full();
      t_mark();
      t_irq();
      report_and_stop();
   end
endmodule : asf_top_tb
`default_nettype wire
